// [rtl/frsrc_pkg.sv]
package frsrc_pkg;
	// Command codes
	localparam logic [7:0] CMD_NOP          = 8'h00;
	localparam logic [7:0] CMD_RESET_ARM    = 8'h66;
	localparam logic [7:0] CMD_RESET_EXEC   = 8'h99;
	localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] CMD_ROW_ERASE    = 8'h64;
	localparam logic [7:0] CMD_ENTER_QUAD   = 8'h35;
	localparam logic [7:0] CMD_EXIT_QUAD    = 8'hf5;
	localparam logic [7:0] CMD_POWER_DOWN   = 8'hb9;
	localparam logic [7:0] CMD_RELEASE      = 8'hab;

	// Security row geometry and addressing
	localparam int         ROWS          = 4;
	localparam int         ROW_BYTES     = 256;
	localparam logic [7:0] ROW_TOP_BYTE  = 8'h00;
	localparam logic [3:0] ROW_MID_LOW   = 4'h0;
	localparam logic [2:0] ERASE_BYTES   = 3'h4;
	localparam logic [7:0] ERASED_BYTE   = 8'hff;

	// Reset values
	localparam logic [7:0] READ_PARAMS_DEFAULT = 8'h00;
	localparam logic [6:0] PIN_IDLE            = 7'h41;

	// Timing
	localparam int CLK_PERIOD_NS      = 50;
	localparam int RESET_PULSE_MIN_NS = 1000;
	localparam int RESET_RECOVERY_NS  = 100000;
	localparam int RESET_PULSE_MIN_CYCLES =
		(RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_RECOVERY_CYCLES =
		RESET_RECOVERY_NS / CLK_PERIOD_NS;
	localparam int ERASE_SETTLE_CYCLES = 1000;
endpackage

// [rtl/frsrc_sync.sv]
`timescale 1ns/1ns
module frsrc_sync #(
	parameter int         WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             reset,
	// Raw and filtered levels
	input  wire logic [WIDTH-1:0] raw,
	output logic      [WIDTH-1:0] level
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// Three stages; a bit moves only when stages two and three agree
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			stage1 <= INIT;
			stage2 <= INIT;
			stage3 <= INIT;
			level  <= INIT;
		end else begin
			stage1 <= raw;
			stage2 <= stage1;
			stage3 <= stage2;
			level  <= (stage2 & stage3) | (level & (stage2 ^ stage3));
		end
	end
endmodule

// [rtl/frsrc_top.sv]
`timescale 1ns/1ns
// Function
// - Command 00h only cancels reset arm
// - Software reset reloads volatile config, normal mode
// - Reset needs 66h immediately followed by 99h
// - Any other command drops the armed state
// - Reset pin only single-line, quad bit clear
// - Reset pin overrides all other inputs
// - Pin reset aborts, wakes, tri-states, defaults
// - Pin reset keeps status and function bits
// - No commands for 100 us after pin reset
// - Reset aborts running erase or write
// - Four security rows of 256 bytes
// - Row program rejected while a cycle runs
// - Rows at middle byte 00h,10h,20h,30h
// - Function bits 7 to 4 lock rows
// - Locked row is read-only
// - Row erase needs write enable latch set
// - Row erase completion clears write enable latch
// - Erase starts when chip select rises
// - Write in progress high while erasing
module frsrc_top #(
	parameter bit HAS_RESET_PIN = 1'b1,
	parameter int SETTLE_CYCLES = frsrc_pkg::ERASE_SETTLE_CYCLES
) (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       reset,
	// Serial bus pins
	input  wire logic       chip_select_n,
	input  wire logic       serial_clk,
	input  wire logic [3:0] io_in,
	output logic      [3:0] io_out,
	output logic      [3:0] io_oe,
	input  wire logic       hw_reset_n,
	// Configuration
	input  wire logic       quad_enable_bit,
	input  wire logic [3:0] row_lock_bit,
	input  wire logic [7:0] nv_config,
	output logic      [7:0] volatile_config,
	output logic      [7:0] read_params,
	// Status
	output logic            write_enable_latch,
	output logic            write_in_progress,
	output logic            four_line_command_mode,
	output logic            deep_power_down,
	output logic            reset_recovering,
	// Row program port from the program engine
	input  wire logic       ext_busy,
	input  wire logic       row_prog_req,
	input  wire logic [9:0] row_prog_addr,
	input  wire logic [7:0] row_prog_data,
	output logic            row_prog_grant,
	// Row read port
	input  wire logic [9:0] row_rd_addr,
	output logic      [7:0] row_rd_data
);
	import frsrc_pkg::*;

	typedef enum logic [1:0] {ER_IDLE, ER_WIPE, ER_SETTLE} frsrc_erase_e;

	logic [6:0]  pins;
	logic        cs_n_s;
	logic        sclk_s;
	logic [3:0]  io_s;
	logic        hw_n_s;
	logic        sclk_d;
	logic        cs_d;
	logic        sclk_rise;
	logic        cs_rise;
	logic        hw_active;
	logic        cmd_ignore;
	logic [7:0]  shift;
	logic [2:0]  bit_cnt;
	logic [2:0]  byte_cnt;
	logic [7:0]  cmd;
	logic [23:0] addr;
	logic [7:0]  next_shift;
	logic [2:0]  next_bit_cnt;
	logic        byte_done;
	logic        cmd_done;
	logic        armed;
	logic        sw_reset;
	logic        frame_clean;
	logic        row_ok;
	logic [1:0]  row_sel;
	logic        erase_start;
	logic        erase_done;
	logic        wen_ok;
	logic [11:0] recovery;
	frsrc_erase_e erase_state;
	logic [1:0]  er_row;
	logic [7:0]  er_ptr;
	logic [15:0] er_timer;
	logic [7:0]  mem [ROWS*ROW_BYTES];

	// Pins from the host cross into the core clock
	frsrc_sync #(.WIDTH(7), .INIT(PIN_IDLE)) u_sync (
		.core_clk (core_clk),
		.reset    (reset),
		.raw      ({hw_reset_n, io_in, serial_clk, chip_select_n}),
		.level    (pins)
	);
	assign cs_n_s = pins[0];
	assign sclk_s = pins[1];
	assign io_s   = pins[5:2];
	assign hw_n_s = pins[6];

	// Edge detection of the filtered bus clock and select
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sclk_d <= 1'b0;
			cs_d   <= 1'b1;
		end else begin
			sclk_d <= sclk_s;
			cs_d   <= cs_n_s;
		end
	end
	assign sclk_rise = sclk_s & ~sclk_d & ~cs_n_s;
	assign cs_rise   = cs_n_s & ~cs_d;

	// Pin reset gated by part option, line mode and quad bit
	// Short glitches die in the filter; a 1 us pulse always lands
	assign hw_active = HAS_RESET_PIN & ~hw_n_s & ~quad_enable_bit
		& ~four_line_command_mode;
	assign cmd_ignore = hw_active | (recovery != 12'h000);

	// Recovery window after the pin reset is released
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			recovery <= 12'h000;
		end else if (hw_active) begin
			recovery <= 12'(RESET_RECOVERY_CYCLES);
		end else if (recovery != 12'h000) begin
			recovery <= recovery - 12'h001;
		end
	end
	assign reset_recovering = cmd_ignore;

	// Bit assembly: one bit per clock, or a nibble in four-line mode
	always_comb begin
		if (four_line_command_mode) begin
			next_shift   = {shift[3:0], io_s};
			next_bit_cnt = bit_cnt + 3'h4;
		end else begin
			next_shift   = {shift[6:0], io_s[0]};
			next_bit_cnt = bit_cnt + 3'h1;
		end
	end
	assign byte_done = sclk_rise & ~cmd_ignore & (next_bit_cnt == 3'h0);
	assign cmd_done  = byte_done & (byte_cnt == 3'h0);
	assign frame_clean = (bit_cnt == 3'h0);

	// Frame shifter, byte counter, command and address capture
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			shift    <= 8'h00;
			bit_cnt  <= 3'h0;
			byte_cnt <= 3'h0;
			cmd      <= 8'h00;
			addr     <= 24'h000000;
		end else if (cs_n_s || cmd_ignore) begin
			bit_cnt  <= 3'h0;
			byte_cnt <= 3'h0;
		end else if (sclk_rise) begin
			shift   <= next_shift;
			bit_cnt <= next_bit_cnt;
			if (next_bit_cnt == 3'h0) begin
				if (byte_cnt == 3'h0) begin
					cmd <= next_shift;
				end else begin
					addr <= {addr[15:0], next_shift};
				end
				if (byte_cnt != 3'h7) begin
					byte_cnt <= byte_cnt + 3'h1;
				end
			end
		end
	end

	// Two-step software reset; 99h only counts straight after 66h
	assign sw_reset = cmd_done & ~deep_power_down & armed
		& (next_shift == CMD_RESET_EXEC);
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			armed <= 1'b0;
		end else if (hw_active) begin
			armed <= 1'b0;
		end else if (cmd_done && !deep_power_down) begin
			// CMD_NOP and every other code fall through to clear
			armed <= (next_shift == CMD_RESET_ARM);
		end
	end

	// Mode, sleep and reloaded configuration
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			four_line_command_mode <= 1'b0;
			deep_power_down        <= 1'b0;
			volatile_config        <= 8'h00;
			read_params            <= READ_PARAMS_DEFAULT;
		end else if (hw_active) begin
			deep_power_down <= 1'b0;
			volatile_config <= nv_config;
			read_params     <= READ_PARAMS_DEFAULT;
		end else if (sw_reset) begin
			four_line_command_mode <= 1'b0;
			volatile_config        <= nv_config;
		end else if (cs_rise && frame_clean && byte_cnt == 3'h1) begin
			if (deep_power_down) begin
				deep_power_down <= (cmd != CMD_RELEASE);
			end else if (cmd == CMD_POWER_DOWN && !write_in_progress) begin
				deep_power_down <= 1'b1;
			end else if (cmd == CMD_ENTER_QUAD) begin
				four_line_command_mode <= 1'b1;
			end else if (cmd == CMD_EXIT_QUAD) begin
				four_line_command_mode <= 1'b0;
			end
		end
	end

	// Row address check: top byte 00h, middle byte 00h, 10h, 20h or 30h
	assign row_ok  = (addr[23:16] == ROW_TOP_BYTE)
		&& (addr[11:8] == ROW_MID_LOW) && (addr[15:14] == 2'b00);
	assign row_sel = addr[13:12];
	assign wen_ok  = cs_rise && frame_clean && byte_cnt == 3'h1
		&& cmd == CMD_WRITE_ENABLE && !deep_power_down
		&& !write_in_progress && !ext_busy;
	// Erase starts at the select edge ending a clean four-byte frame
	assign erase_start = cs_rise && frame_clean && !deep_power_down
		&& cmd == CMD_ROW_ERASE && byte_cnt == ERASE_BYTES
		&& write_enable_latch
		&& row_ok && !row_lock_bit[row_sel]
		&& !write_in_progress && !ext_busy;
	assign erase_done = (erase_state == ER_SETTLE)
		&& (er_timer == 16'h0000);

	// Write enable latch; completion of the erase drops it
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			write_enable_latch <= 1'b0;
		end else if (hw_active || sw_reset) begin
			write_enable_latch <= 1'b0;
		end else if (wen_ok) begin
			write_enable_latch <= 1'b1;
		end else if (erase_done) begin
			write_enable_latch <= 1'b0;
		end
	end

	// Erase engine: wipe each byte, then hold busy for the settle time
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			erase_state <= ER_IDLE;
			er_row      <= 2'b00;
			er_ptr      <= 8'h00;
			er_timer    <= 16'h0000;
		end else if (hw_active || sw_reset) begin
			erase_state <= ER_IDLE;
		end else begin
			unique case (erase_state)
				ER_IDLE: begin
					if (erase_start) begin
						erase_state <= ER_WIPE;
						er_row      <= row_sel;
						er_ptr      <= 8'h00;
					end
				end
				ER_WIPE: begin
					er_ptr <= er_ptr + 8'h01;
					if (er_ptr == 8'(ROW_BYTES - 1)) begin
						erase_state <= ER_SETTLE;
						er_timer    <= 16'(SETTLE_CYCLES);
					end
				end
				ER_SETTLE: begin
					if (er_timer == 16'h0000) begin
						erase_state <= ER_IDLE;
					end else begin
						er_timer <= er_timer - 16'h0001;
					end
				end
			endcase
		end
	end
	assign write_in_progress = (erase_state != ER_IDLE);

	// Program requests refused while any cycle runs or row is locked
	assign row_prog_grant = row_prog_req && !write_in_progress
		&& !ext_busy && !row_lock_bit[row_prog_addr[9:8]]
		&& !cmd_ignore;

	// Row storage; not reset so contents survive every reset
	always_ff @(posedge core_clk) begin
		if (erase_state == ER_WIPE && !hw_active && !sw_reset) begin
			mem[{er_row, er_ptr}] <= ERASED_BYTE;
		end else if (row_prog_grant) begin
			mem[row_prog_addr] <= mem[row_prog_addr] & row_prog_data;
		end
		row_rd_data <= mem[row_rd_addr];
	end

	// Output stays released: none of these commands return data
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			io_out <= 4'h0;
			io_oe  <= 4'h0;
		end else begin
			io_out <= 4'h0;
			io_oe  <= 4'h0;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence seq_arm;
		cmd_done && !deep_power_down && next_shift == CMD_RESET_ARM;
	endsequence
	sequence seq_other_cmd;
		cmd_done && !deep_power_down && next_shift != CMD_RESET_ARM;
	endsequence

	a_nop_disarm: assert property (
		cmd_done && !deep_power_down && next_shift == CMD_NOP
		|=> !armed && $stable(write_enable_latch))
		else $error("nop left reset armed");
	a_exec_needs_arm: assert property (
		sw_reset |-> armed && $past(armed) == armed)
		else $error("reset executed without arm");
	a_arm_dropped: assert property (
		seq_other_cmd |=> !armed)
		else $error("arm survived other command");
	a_sw_reload: assert property (
		sw_reset |=> volatile_config == $past(nv_config)
		&& !four_line_command_mode && !write_in_progress)
		else $error("software reset did not reload");
	a_pin_override: assert property (
		hw_active |=> !write_in_progress && !write_enable_latch
		&& !deep_power_down && read_params == READ_PARAMS_DEFAULT)
		else $error("pin reset not applied");
	a_pin_gated: assert property (
		(quad_enable_bit || four_line_command_mode) |-> !hw_active)
		else $error("pin reset acted in quad mode");
	a_recovery_hold: assert property (
		$fell(hw_active) |-> recovery == 12'(RESET_RECOVERY_CYCLES)
		##1 !cmd_done [*8])
		else $error("command accepted during recovery");
	a_prog_reject: assert property (
		(write_in_progress || ext_busy) |-> !row_prog_grant)
		else $error("row program granted while busy");
	a_lock_readonly: assert property (
		row_prog_grant |-> !row_lock_bit[row_prog_addr[9:8]])
		else $error("locked row programmed");
	a_erase_start: assert property (
		erase_start |=> write_in_progress ##1 write_in_progress)
		else $error("erase did not start on select rise");
	a_erase_needs_wel: assert property (
		$rose(write_in_progress) |-> $past(write_enable_latch))
		else $error("erase started without latch");
	a_locked_ignored: assert property (
		cs_rise && cmd == CMD_ROW_ERASE && row_lock_bit[row_sel]
		&& !write_in_progress |=> !write_in_progress)
		else $error("locked row erase ran");
	a_erase_done: assert property (
		erase_done |=> !write_in_progress && !write_enable_latch)
		else $error("erase end left latch set");
	a_erase_ones: assert property (
		erase_done |-> mem[{er_row, 8'h00}] == ERASED_BYTE)
		else $error("erased row not all ones");
	a_abort_reset: assert property (
		write_in_progress && (hw_active || sw_reset) |=> !write_in_progress)
		else $error("reset did not abort erase");
endmodule

// [testbench/frsrc_host_model.sv]
`timescale 1ns/1ns
module frsrc_host_model (
	// Clock
	input  wire logic       core_clk,
	// Bus pins
	output logic            chip_select_n,
	output logic            serial_clk,
	output logic      [3:0] io_in
);
	// Idle bus: deselected, link clock parked low
	initial begin
		chip_select_n = 1'b1;
		serial_clk = 1'b0;
		io_in = 4'h0;
	end
	// Half of the 400 ns link period, moved just after a core edge
	task automatic half();
		repeat (4) @(posedge core_clk);
		#1;
	endtask
	// Sends the top n bytes of b MSB first, select low for the whole frame
	// w is the line count: 1 for single-line, 4 for nibble transfers
	task automatic frame(input logic [31:0] b, input int n, input int w = 1);
		half();
		chip_select_n = 1'b0;
		for (int i = 0; i < 8 * n; i += w) begin
			if (w == 4) begin
				io_in = b[31 - i -: 4];
			end else begin
				io_in[0] = b[31 - i];
			end
			half();
			serial_clk = 1'b1;
			half();
			serial_clk = 1'b0;
		end
		half();
		chip_select_n = 1'b1;
		// Released lines show the inverse so stale data never looks valid
		io_in = ~io_in;
		half();
	endtask
endmodule

// [testbench/frsrc_top_bench.sv]
`timescale 1ns/1ns
module frsrc_top_bench;
	import frsrc_pkg::*;
	logic       core_clk, reset, chip_select_n, serial_clk;
	logic       hw_reset_n, quad_enable_bit, ext_busy, row_prog_req;
	logic [3:0] io_in, io_out, io_oe, row_lock_bit;
	logic [7:0] nv_config, volatile_config, read_params, cfg;
	logic [7:0] row_prog_data, row_rd_data;
	logic       write_enable_latch, write_in_progress, row_prog_grant;
	logic       four_line_command_mode, deep_power_down, reset_recovering;
	logic [9:0] row_prog_addr, row_rd_addr;
	logic [1:0] r;
	logic [31:0] seed;
	int         mismatches, check_count, cycles;

	// Settle shortened to keep each erase near 260 cycles
	frsrc_top #(.SETTLE_CYCLES(4)) u_frsrc_top (.core_clk, .reset,
		.chip_select_n, .serial_clk, .io_in, .io_out, .io_oe, .hw_reset_n,
		.quad_enable_bit, .row_lock_bit, .nv_config, .volatile_config,
		.read_params, .write_enable_latch, .write_in_progress,
		.four_line_command_mode, .deep_power_down, .reset_recovering,
		.ext_busy, .row_prog_req, .row_prog_addr, .row_prog_data,
		.row_prog_grant, .row_rd_addr, .row_rd_data);
	frsrc_host_model u_host (.core_clk, .chip_select_n, .serial_clk, .io_in);

	// 50 ns core clock
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// Hang guard, well above the few thousand cycles the run needs
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string m);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic cmd(input logic [7:0] c, input int w = 1);
		u_host.frame({c, 24'h0}, 1, w);
		idle(4);
	endtask
	// Row erase with a random low address byte
	task automatic erase(input logic [1:0] row);
		u_host.frame({CMD_ROW_ERASE, ROW_TOP_BYTE, 2'b00, row, ROW_MID_LOW,
			8'(xs())}, 4);
		// Select rise needs the filter latency before the engine reacts
		idle(4);
	endtask
	task automatic rd(input logic [7:0] exp, input string m);
		row_rd_addr = {r, 8'h5a};
		idle(2);
		chk(row_rd_data, exp, m);
	endtask
	task automatic report_and_stop();
		if (mismatches == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		seed = 32'd22;
		reset = 1'b1;
		hw_reset_n = 1'b1;
		quad_enable_bit = 1'b0;
		ext_busy = 1'b0;
		row_prog_req = 1'b0;
		row_prog_addr = 10'h000;
		row_prog_data = 8'h00;
		row_rd_addr = 10'h000;
		row_lock_bit = 4'h0;
		nv_config = 8'(xs());
		idle(6);
		reset = 1'b0;
		chk({io_oe, 2'b00, write_enable_latch, write_in_progress}, 8'h00,
			"idle state");
		cmd(CMD_RESET_ARM);
		cmd(CMD_RESET_EXEC);
		chk(volatile_config, nv_config, "soft reset reload");
		cfg = nv_config;
		nv_config = ~cfg;
		cmd(CMD_RESET_ARM);
		cmd(CMD_NOP);
		cmd(CMD_RESET_EXEC);
		chk(volatile_config, cfg, "nop kept arm");
		cmd(CMD_RESET_ARM);
		cmd(CMD_WRITE_ENABLE);
		cmd(CMD_RESET_EXEC);
		chk(volatile_config, cfg, "other cmd kept arm");
		chk(write_enable_latch, 1'b1, "write enable");
		cmd(CMD_RESET_ARM);
		cmd(CMD_RESET_EXEC);
		chk(volatile_config, nv_config, "second reload");
		cmd(CMD_ENTER_QUAD);
		chk(four_line_command_mode, 1'b1, "quad entry");
		cfg = nv_config;
		nv_config = ~cfg;
		cmd(CMD_RESET_ARM, 4);
		cmd(CMD_NOP, 4);
		cmd(CMD_RESET_EXEC, 4);
		chk(volatile_config, cfg, "quad nop kept arm");
		cmd(CMD_RESET_ARM, 4);
		cmd(CMD_RESET_EXEC, 4);
		chk({four_line_command_mode, volatile_config == nv_config}, 8'h01,
			"quad soft reset");
		r = 2'(xs());
		erase(r);
		chk(write_in_progress, 1'b0, "erase without latch");
		cmd(CMD_WRITE_ENABLE);
		erase(r);
		chk(write_in_progress, 1'b1, "erase start");
		idle(200);
		chk(write_in_progress, 1'b1, "erase too short");
		row_prog_req = 1'b1;
		row_prog_addr = {r, 8'h5a};
		row_prog_data = 8'h3c;
		#1;
		chk(row_prog_grant, 1'b0, "program while erasing");
		row_prog_req = 1'b0;
		for (int i = 0; i < 400 && write_in_progress !== 1'b0; i++) idle(1);
		chk({write_in_progress, write_enable_latch}, 8'h00, "erase end");
		rd(ERASED_BYTE, "erased byte");
		row_prog_req = 1'b1;
		#1;
		chk(row_prog_grant, 1'b1, "program grant");
		idle(1);
		ext_busy = 1'b1;
		#1;
		chk(row_prog_grant, 1'b0, "program while busy");
		row_prog_req = 1'b0;
		ext_busy = 1'b0;
		rd(8'h3c, "programmed byte");
		row_lock_bit[r] = 1'b1;
		cmd(CMD_WRITE_ENABLE);
		erase(r);
		chk(write_in_progress, 1'b0, "locked erase");
		row_prog_req = 1'b1;
		#1;
		chk(row_prog_grant, 1'b0, "locked program");
		row_prog_req = 1'b0;
		rd(8'h3c, "locked row kept");
		row_lock_bit = 4'h0;
		quad_enable_bit = 1'b1;
		hw_reset_n = 1'b0;
		idle(RESET_PULSE_MIN_CYCLES);
		hw_reset_n = 1'b1;
		idle(4);
		chk(write_enable_latch, 1'b1, "pin ignored in quad");
		quad_enable_bit = 1'b0;
		erase(r);
		chk(write_in_progress, 1'b1, "busy before pin reset");
		nv_config = 8'(xs());
		hw_reset_n = 1'b0;
		idle(RESET_PULSE_MIN_CYCLES);
		chk({io_oe, write_in_progress, deep_power_down, write_enable_latch,
			reset_recovering}, 8'h01, "pin reset");
		chk(read_params, READ_PARAMS_DEFAULT, "read params");
		chk(volatile_config, nv_config, "pin reload");
		hw_reset_n = 1'b1;
		cmd(CMD_WRITE_ENABLE);
		chk(write_enable_latch, 1'b0, "cmd in recovery");
		idle(1500);
		chk(reset_recovering, 1'b1, "recovery too short");
		for (int i = 0; i < RESET_RECOVERY_CYCLES && reset_recovering !== 1'b0;
			i++) idle(1);
		chk(reset_recovering, 1'b0, "recovery end");
		cmd(CMD_WRITE_ENABLE);
		chk(write_enable_latch, 1'b1, "cmd after recovery");
		cmd(CMD_POWER_DOWN);
		chk(deep_power_down, 1'b1, "sleep entry");
		hw_reset_n = 1'b0;
		idle(RESET_PULSE_MIN_CYCLES);
		chk({deep_power_down, write_enable_latch}, 8'h00, "pin wake");
		chk({io_out, io_oe}, 8'h00, "bus released");
		hw_reset_n = 1'b1;
		report_and_stop();
	end
endmodule
